// [rtl/burst_sram_consts.vh]
// Constants for the pipelined burst SRAM access block
`ifndef BURST_SRAM_CONSTS_VH
`define BURST_SRAM_CONSTS_VH
`define ADDR_W 6
`define DATA_W 32
`define LANES 4
`define LANE_W 8
`define WORDS 64
`define BURST_W 2
`define BURST_ONE 2'h1
`define SLEEP_CYC 2'h2
`define SLEEP_CNT_W 2
`define CNT_ZERO 2'h0
`define ST_IDLE 2'h0
`define ST_READ 2'h1
`define ST_WRITE 2'h2
`define ST_WRITE2 2'h3
`endif

// [rtl/burst_counter.v]
// Two-bit wraparound burst counter, interleaved or linear order
`timescale 1ns/100ps
`include "burst_sram_consts.vh"
module burst_counter (
  input wire clk_in,
  input wire rstn_in,
  input wire load_in,
  input wire advance_in,
  input wire linear_in,
  input wire [`BURST_W-1:0] start_in,
  output wire [`BURST_W-1:0] addr_out
);
  reg [`BURST_W-1:0] start_q;
  reg [`BURST_W-1:0] count_q;

  function [`BURST_W-1:0] burst_seq;
    input [`BURST_W-1:0] start;
    input [`BURST_W-1:0] count;
    input linear;
    begin
      // Interleaved is start XOR count; linear is start plus count mod four
      if (linear)
        burst_seq = start + count;
      else
        burst_seq = start ^ count;
    end
  endfunction

  // Looks one step ahead while advancing, so a continued burst uses the next address
  assign addr_out = advance_in ? burst_seq(start_q, count_q + `BURST_ONE, linear_in) :
    burst_seq(start_q, count_q, linear_in);

  always @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      start_q <= `CNT_ZERO;
      count_q <= `CNT_ZERO;
    end
    else if (load_in)
    begin
      start_q <= start_in;
      count_q <= `CNT_ZERO;
    end
    else if (advance_in)
    begin
      count_q <= count_q + `BURST_ONE;
    end
  end
endmodule // burst_counter

// [rtl/burst_sram.v]
// Access control and storage of a pipelined burst SRAM
// Operation
// - Controller strobe write start condition
// - Controller strobe write completes same cycle
// - Controller write loads address, ignores advance
// - Global write stores whole word
// - Byte write updates selected lanes only
// - Write detected disables output drivers
// - Two-bit counter from low address, order strap
// - Advance low steps the burst counter
// - Strap high gives interleaved XOR order
// - Strap low gives linear increment order
// - Bursts for reads and writes alike
// - Sleep keeps data, three-states outputs
// - Three cycles to enter, three to leave
// - Pending access dropped on sleep entry
// - Deselect cycle three-states the outputs
// - Processor strobe always starts a read
// - Writes only after processor start or controller
// - Write indication from global or byte gates
// - Output enable combinational, masked in writes
// - Read data one cycle through output register
// - Processor strobe ignored when first select high
// - Processor-started write takes two clocks
`timescale 1ns/100ps
`include "burst_sram_consts.vh"
module burst_sram (
  input wire clk_in,
  input wire rstn_in,
  input wire [`ADDR_W-1:0] addr_in,
  input wire controller_addr_strobe_n_in,
  input wire processor_addr_strobe_n_in,
  input wire burst_advance_n_in,
  input wire pipeline_chip_select_n_in,
  input wire depth_chip_select_high_in,
  input wire depth_chip_select_low_n_in,
  input wire global_write_n_in,
  input wire byte_write_gate_n_in,
  input wire [`LANES-1:0] byte_lane_select_n_in,
  input wire output_enable_n_in,
  input wire sleep_request_in,
  input wire burst_order_in,
  input wire [`DATA_W-1:0] data_in,
  output wire [`DATA_W-1:0] data_out,
  output wire data_oe_n_out,
  output wire asleep_out
);
  reg [`DATA_W-1:0] mem_q [0:`WORDS-1];
  reg [`ADDR_W-`BURST_W-1:0] high_addr_q;
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [`DATA_W-1:0] dout_q;
  reg drive_q;
  reg zz_meta_q;
  reg zz_sync_q;
  reg asleep_q;
  reg [`ADDR_W-1:0] rd_addr_q;
  reg order_q;
  reg strap_taken_q;
  wire [`BURST_W-1:0] burst_addr;
  wire [`ADDR_W-1:0] cur_addr;
  wire write_ind;
  wire all_sel;
  wire proc_start;
  wire ctrl_start;
  wire deselect;
  wire ctrl_write;
  wire cont_write;
  wire do_write;
  wire burst_advance_n;
  wire load;
  wire write_now;
  integer i;

  function [`DATA_W-1:0] lane_merge;
    input [`DATA_W-1:0] old_word;
    input [`DATA_W-1:0] new_word;
    input [`LANES-1:0] lane_n;
    input glob_n;
    integer k;
    begin
      lane_merge = old_word;
      for (k = 0; k < `LANES; k = k + 1)
        if (!glob_n || !lane_n[k])
          lane_merge[k*`LANE_W +: `LANE_W] = new_word[k*`LANE_W +: `LANE_W];
    end
  endfunction

  assign write_ind = !global_write_n_in ||
    (!byte_write_gate_n_in && (byte_lane_select_n_in != {`LANES{1'b1}}));
  assign all_sel = !pipeline_chip_select_n_in && depth_chip_select_high_in &&
    !depth_chip_select_low_n_in;
  // Processor strobe counts only with the first select low
  assign proc_start = !processor_addr_strobe_n_in && !pipeline_chip_select_n_in;
  assign ctrl_start = !controller_addr_strobe_n_in;
  assign deselect = (pipeline_chip_select_n_in && ctrl_start) ||
    (!all_sel && (proc_start || ctrl_start));
  assign ctrl_write = ctrl_start && processor_addr_strobe_n_in && all_sel &&
    write_ind;
  // Continue/suspend cycle of an open burst, no strobe starts anything
  assign cont_write = !proc_start && !ctrl_start && (state_q != `ST_IDLE) &&
    write_ind;
  assign do_write = !asleep_q && (ctrl_write || cont_write);
  assign load = !asleep_q && !deselect && (proc_start || ctrl_start) && all_sel;
  // Advance disregarded on any load cycle, including controller writes
  assign burst_advance_n = !asleep_q && !load && !burst_advance_n_in && (state_q != `ST_IDLE);
  // Address of this cycle: next step when advancing, current when suspended
  assign cur_addr = {high_addr_q, burst_addr};
  assign write_now = (state_q == `ST_WRITE) || (state_q == `ST_WRITE2);

  burst_counter u_counter (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .load_in(load),
    .advance_in(burst_advance_n),
    .linear_in(!order_q),
    .start_in(addr_in[`BURST_W-1:0]),
    .addr_out(burst_addr)
  );

  // Output enable is combinational; masked in writes, sleep and deselect
  assign data_oe_n_out = !(drive_q && !output_enable_n_in && !write_now &&
    !asleep_q);
  assign data_out = dout_q;
  assign asleep_out = asleep_q;

  always @*
  begin
    state_d = state_q;
    if (asleep_q)
      state_d = `ST_IDLE;
    else if (deselect)
      state_d = `ST_IDLE;
    else if (proc_start && all_sel)
      state_d = `ST_READ;
    else if (ctrl_start && all_sel)
      state_d = write_ind ? `ST_WRITE : `ST_READ;
    else
    begin
      case (state_q)
        `ST_IDLE: state_d = `ST_IDLE;
        `ST_READ: state_d = write_ind ? `ST_WRITE2 : `ST_READ;
        `ST_WRITE: state_d = write_ind ? `ST_WRITE : `ST_READ;
        `ST_WRITE2: state_d = write_ind ? `ST_WRITE2 : `ST_READ;
        default: state_d = `ST_IDLE;
      endcase
    end
  end

  always @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      state_q <= `ST_IDLE;
      high_addr_q <= {(`ADDR_W-`BURST_W){1'b0}};
      dout_q <= {`DATA_W{1'b0}};
      drive_q <= 1'b0;
      zz_meta_q <= 1'b0;
      zz_sync_q <= 1'b0;
      asleep_q <= 1'b0;
      rd_addr_q <= {`ADDR_W{1'b0}};
      order_q <= 1'b1;
      strap_taken_q <= 1'b0;
    end
    else
    begin
      // Strap is static, so catch it once after reset release
      if (!strap_taken_q)
      begin
        order_q <= burst_order_in;
        strap_taken_q <= 1'b1;
      end
      zz_meta_q <= sleep_request_in;
      zz_sync_q <= zz_meta_q;
      // The two synchroniser stages plus this register give the three-cycle entry and exit
      asleep_q <= zz_sync_q;
      state_q <= state_d;
      if (load)
        high_addr_q <= addr_in[`ADDR_W-1:`BURST_W];
      // Address taken at this rise is read out through the output register at the next
      rd_addr_q <= load ? addr_in : cur_addr;
      dout_q <= mem_q[rd_addr_q];
      // Drive starts only once a read word has reached the output register
      drive_q <= !asleep_q && !deselect && (state_q == `ST_READ);
    end
  end

  // Storage has no reset so contents survive sleep untouched
  always @(posedge clk_in)
  begin
    if (do_write)
    begin
      if (ctrl_write)
        mem_q[addr_in] <= lane_merge(mem_q[addr_in], data_in, byte_lane_select_n_in,
          global_write_n_in);
      else
        mem_q[cur_addr] <= lane_merge(mem_q[cur_addr], data_in, byte_lane_select_n_in,
          global_write_n_in);
    end
  end

  initial
  begin
    for (i = 0; i < `WORDS; i = i + 1)
      mem_q[i] = {`DATA_W{1'b0}};
  end
endmodule // burst_sram

// [test/burst_sram_checker.sv]
// Port assertions for the burst SRAM access block
`timescale 1ns/100ps
`include "burst_sram_consts.vh"
module burst_sram_checker (
  input wire clk_in,
  input wire rstn_in,
  input wire controller_addr_strobe_n_in,
  input wire processor_addr_strobe_n_in,
  input wire pipeline_chip_select_n_in,
  input wire global_write_n_in,
  input wire byte_write_gate_n_in,
  input wire [`LANES-1:0] byte_lane_select_n_in,
  input wire output_enable_n_in,
  input wire sleep_request_in,
  input wire data_oe_n_out,
  input wire asleep_out
);
  wire wr = !global_write_n_in || (!byte_write_gate_n_in && !(&byte_lane_select_n_in));
  wire go = !controller_addr_strobe_n_in && processor_addr_strobe_n_in
    && !pipeline_chip_select_n_in && !sleep_request_in && !asleep_out;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  sequence s_cwrite;
    go && wr;
  endsequence
  sequence s_read;
    go && !wr ##1 controller_addr_strobe_n_in && processor_addr_strobe_n_in && !wr &&
      !sleep_request_in && !asleep_out ##1 !output_enable_n_in && !asleep_out;
  endsequence
  a_write_quiet: assert property (s_cwrite |=> data_oe_n_out)
    else $error("drivers on during write");
  a_read_drive: assert property (s_read |-> !data_oe_n_out)
    else $error("read data not driven");
  a_oe_gate: assert property (output_enable_n_in |-> data_oe_n_out)
    else $error("driving with enable high");
  a_sleep_quiet: assert property (asleep_out |-> data_oe_n_out)
    else $error("driving while asleep");
  a_sleep_enter: assert property (sleep_request_in [*6] |-> asleep_out)
    else $error("sleep not entered");
  a_sleep_leave: assert property (!sleep_request_in [*6] |-> !asleep_out)
    else $error("sleep not left");
  a_enter_delay: assert property ($rose(sleep_request_in) && !asleep_out |=> !asleep_out)
    else $error("sleep entered too soon");
  a_deselect_off: assert property (!controller_addr_strobe_n_in && pipeline_chip_select_n_in
    |=> data_oe_n_out)
    else $error("driving after deselect");
endmodule // burst_sram_checker
bind burst_sram burst_sram_checker i_chk (.clk_in, .rstn_in, .controller_addr_strobe_n_in,
  .processor_addr_strobe_n_in, .pipeline_chip_select_n_in, .global_write_n_in,
  .byte_write_gate_n_in, .byte_lane_select_n_in, .output_enable_n_in, .sleep_request_in,
  .data_oe_n_out, .asleep_out);

// [test/cache_master_model.sv]
// Cache controller model: turns an operation code into bus pin levels
`timescale 1ns/100ps
module cache_master_model (
  input wire [2:0] op_in,
  input wire [1:0] wmode_in,
  output wire ctl_n_out,
  output wire cpu_n_out,
  output wire step_n_out,
  output wire sel1_n_out,
  output wire sel2_out,
  output wire sel3_n_out,
  output wire glob_n_out,
  output wire gate_n_out,
  output wire oe_n_out
);
  // Codes: 0 idle, 1 controller start, 2 processor start, 3 burst step, 4 deselect
  assign ctl_n_out = !(op_in == 3'h1 || op_in == 3'h4);
  assign cpu_n_out = op_in != 3'h2;
  // Step held low on a controller start too, the load must win
  assign step_n_out = !(op_in == 3'h1 || op_in == 3'h3);
  assign sel1_n_out = op_in == 3'h0 || op_in == 3'h4;
  assign sel2_out = 1'h1;
  assign sel3_n_out = 1'h0;
  assign glob_n_out = wmode_in != 2'h1;
  assign gate_n_out = wmode_in != 2'h2;
  // Enable off with any write so the shared lines never fight
  assign oe_n_out = wmode_in != 2'h0;
endmodule // cache_master_model

// [test/burst_sram_tb.sv]
// Self-checking bench for the burst SRAM access block
`timescale 1ns/100ps
module burst_sram_tb;
  reg clk_in = 0;
  reg rstn_in = 0;
  reg burst_order_in = 1;
  reg sleep_request_in = 0;
  reg [5:0] addr_in = 0;
  reg [31:0] data_in = 0;
  reg [3:0] byte_lane_select_n_in = 4'hF;
  reg [2:0] op_q = 0;
  reg [1:0] wm_q = 0;
  reg [31:0] lfsr_q = 32'h2C;
  reg [31:0] mem [0:63];
  reg [31:0] rd_exp;
  reg rd_pend = 0;
  reg [31:0] rd_exp2;
  reg rd_pend2 = 0;
  reg [5:0] base;
  reg [1:0] cnt;
  reg [5:0] cur;
  integer fail_count = 0;
  integer samples_checked = 0;
  integer m;
  integer k;
  wire controller_addr_strobe_n_in, processor_addr_strobe_n_in, burst_advance_n_in;
  wire pipeline_chip_select_n_in, depth_chip_select_high_in, depth_chip_select_low_n_in;
  wire global_write_n_in, byte_write_gate_n_in, output_enable_n_in, data_oe_n_out, asleep_out;
  wire [31:0] data_out;
  always #10 clk_in = ~clk_in;
  cache_master_model i_cache_master_model (.op_in(op_q), .wmode_in(wm_q),
    .ctl_n_out(controller_addr_strobe_n_in), .cpu_n_out(processor_addr_strobe_n_in),
    .step_n_out(burst_advance_n_in), .sel1_n_out(pipeline_chip_select_n_in),
    .sel2_out(depth_chip_select_high_in), .sel3_n_out(depth_chip_select_low_n_in),
    .glob_n_out(global_write_n_in), .gate_n_out(byte_write_gate_n_in),
    .oe_n_out(output_enable_n_in));
  burst_sram i_burst_sram (.clk_in, .rstn_in, .addr_in, .controller_addr_strobe_n_in,
    .processor_addr_strobe_n_in, .burst_advance_n_in, .pipeline_chip_select_n_in,
    .depth_chip_select_high_in, .depth_chip_select_low_n_in, .global_write_n_in,
    .byte_write_gate_n_in, .byte_lane_select_n_in, .output_enable_n_in, .sleep_request_in,
    .burst_order_in, .data_in, .data_out, .data_oe_n_out, .asleep_out);
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task check(input [31:0] got, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp)
      begin
        fail_count = fail_count + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task final_report;
    begin
      $display("checked=%0d failed=%0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  // One bus cycle; read data from the cycle before last is compared here
  task cyc(input [2:0] o, input [1:0] w, input [5:0] a, input [3:0] ln);
    begin
      @(posedge clk_in);
      op_q <= o;
      wm_q <= w;
      addr_in <= a;
      data_in <= lfsr_q;
      byte_lane_select_n_in <= ln;
      #1;
      // A read taken at one rise shows after the following rise
      if (rd_pend2)
        check(data_out, rd_exp2);
      rd_pend2 = rd_pend;
      rd_exp2 = rd_exp;
      rd_pend = 0;
      if (o == 3'h1 || o == 3'h2)
      begin
        base = a;
        cnt = 0;
      end
      if (o == 3'h2)
        w = 0;
      if (o == 3'h3)
        cnt = cnt + 2'h1;
      cur = {base[5:2], burst_order_in ? base[1:0] ^ cnt : base[1:0] + cnt};
      if (sleep_request_in || o == 3'h4 || (o == 3'h0 && w == 2'h0))
        rd_pend = 0;
      else if (w == 2'h1)
        mem[cur] = lfsr_q;
      else if (w == 2'h2)
      begin
        for (k = 0; k < 4; k = k + 1)
          if (!ln[k])
            mem[cur][8*k +: 8] = lfsr_q[8*k +: 8];
      end
      else
      begin
        rd_pend = 1;
        rd_exp = mem[cur];
      end
      lfsr_q = lfsr(lfsr_q);
    end
  endtask
  initial
  begin
    for (k = 0; k < 64; k = k + 1)
      mem[k] = 0;
    // Strap is only taken after reset, so each order needs its own reset
    for (m = 0; m < 2; m = m + 1)
    begin
      @(posedge clk_in) rstn_in <= 0;
      burst_order_in <= !m;
      repeat (4) @(posedge clk_in);
      rstn_in <= 1;
      for (k = 0; k < 4; k = k + 1)
      begin
        cyc(3'h1, 2'h1, 6'h5 * k[5:0], 4'hF);
        repeat (3) cyc(3'h3, 2'h1, 6'h0, 4'hF);
        cyc(3'h2, 2'h1, 6'h5 * k[5:0], 4'hF);
        repeat (3) cyc(3'h3, 2'h0, 6'h0, 4'hF);
        repeat (2) cyc(3'h0, 2'h0, 6'h0, 4'hF);
      end
    end
    for (m = 0; m < 15; m = m + 1)
    begin
      cyc(3'h1, 2'h1, 6'h20 + m[5:0], 4'hF);
      cyc(3'h1, 2'h2, 6'h20 + m[5:0], m[3:0]);
      cyc(3'h1, 2'h0, 6'h20 + m[5:0], 4'hF);
    end
    cyc(3'h2, 2'h0, 6'h31, 4'hF);
    cyc(3'h0, 2'h1, 6'h0, 4'hF);
    cyc(3'h1, 2'h0, 6'h31, 4'hF);
    cyc(3'h4, 2'h0, 6'h0, 4'hF);
    @(posedge clk_in) sleep_request_in <= 1;
    repeat (8) cyc(3'h0, 2'h0, 6'h0, 4'hF);
    check(asleep_out, 32'h1);
    check(data_oe_n_out, 32'h1);
    cyc(3'h1, 2'h1, 6'h20, 4'hF);
    cyc(3'h0, 2'h0, 6'h0, 4'hF);
    @(posedge clk_in) sleep_request_in <= 0;
    repeat (8) cyc(3'h0, 2'h0, 6'h0, 4'hF);
    check(asleep_out, 32'h0);
    cyc(3'h1, 2'h0, 6'h20, 4'hF);
    repeat (3) cyc(3'h0, 2'h0, 6'h0, 4'hF);
    final_report;
  end
  initial
  begin
    #20000;
    fail_count = fail_count + 1;
    final_report;
  end
endmodule // burst_sram_tb
